// ### rscm_measure.sv
// Contract
// [RULE_01] divider emits one event per 32 reference rising edges, every 32 s
// [RULE_02] cycle counter counts kernel cycles, latches its count on each event
// [RULE_03] counter clears right after latching, one capture per window
// [RULE_04] capture compared to expected count, sets sign bit and 9-bit magnitude
// [RULE_05] measurement and correction repeat every window without stopping
// [RULE_06] corrected calibration settles within two windows, 64 seconds
// [RULE_07] cycle counter wider than 20 bits, no wrap in one window
// [RULE_08] with only a 16-bit counter, controller also counts its overflows
// [RULE_09] captured count holds unchanged between window events
`timescale 1ns/10ps
`default_nettype none
module rscm_measure
  import rscm_pkg::*;
#(
  parameter int unsigned CNT_W = RSCM_CNT_W,
  parameter logic [CNT_W-1:0] EXP_CYC = RSCM_EXP_CYC[CNT_W-1:0],
  parameter int unsigned REF_DIV = RSCM_REF_DIV
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ref_1hz,
  output logic window_event,
  output logic [CNT_W-1:0] captured_cycle_count,
  output logic calibration_add_pulses,
  output logic [RSCM_MAG_W-1:0] calibration_mask_pulses,
  output logic calibration_update
);
  // narrow counters would wrap inside a 32 s window
  if (CNT_W <= 20) begin : g_width_check // RULE_07
    $error("cycle counter must be wider than 20 bits");
  end

  // distance between capture and target, clipped to the field
  function automatic logic [RSCM_MAG_W-1:0] rscm_mag_clip(
    input logic [CNT_W-1:0] a,
    input logic [CNT_W-1:0] b
  );
    logic [CNT_W-1:0] d;
    d = (a >= b) ? (a - b) : (b - a);
    rscm_mag_clip = (d > CNT_W'(RSCM_MAG_MAX)) ? RSCM_MAG_MAX :
                    d[RSCM_MAG_W-1:0];
  endfunction : rscm_mag_clip

  // reference pin is asynchronous: two flops, then edge detect
  logic ref_s1_r;
  logic ref_s2_r;
  logic ref_s3_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
    end else begin
      ref_s1_r <= ref_1hz;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
    end
  end

  rscm_div_if div_bus ();
  assign div_bus.ref_edge = ref_s2_r & ~ref_s3_r;

  rscm_ref_divider #(
    .REF_DIV(REF_DIV)
  ) u_div (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .bus(div_bus)
  );

  logic evt;
  assign evt = div_bus.window_evt;
  assign window_event = evt;

  // capture state
  rscm_state_type state_r;
  rscm_state_type state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] cap_r;
  logic [CNT_W-1:0] cap_nxt;
  logic upd_pend_r;
  logic upd_pend_nxt;

  // count includes the event cycle, so a capture is the exact spacing
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 1'b1; // RULE_02
    cap_nxt = cap_r; // RULE_09
    upd_pend_nxt = 1'b0;
    if (evt) begin
      cap_nxt = cnt_r + 1'b1; // RULE_02
      cnt_nxt = '0; // RULE_03
      case (state_r)
        // first window after reset is partial, so it is not trusted
        RSCM_WAIT_FIRST: begin
          state_nxt = RSCM_MEASURE;
        end
        RSCM_MEASURE: begin
          state_nxt = RSCM_MEASURE; // RULE_05
          upd_pend_nxt = 1'b1;
        end
        default: begin
          state_nxt = RSCM_WAIT_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= RSCM_WAIT_FIRST;
      cnt_r <= '0;
      cap_r <= '0;
      upd_pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cap_r <= cap_nxt;
      upd_pend_r <= upd_pend_nxt;
    end
  end

  // calibration word, updated one cycle after each trusted capture
  logic add_r;
  logic add_nxt;
  logic [RSCM_MAG_W-1:0] mag_r;
  logic [RSCM_MAG_W-1:0] mag_nxt;
  logic upd_r;
  logic upd_nxt;

  // slow kernel clock needs pulses added, fast one needs pulses masked
  always_comb begin
    add_nxt = add_r;
    mag_nxt = mag_r;
    upd_nxt = 1'b0;
    if (upd_pend_r) begin
      add_nxt = (cap_r < EXP_CYC); // RULE_04
      mag_nxt = rscm_mag_clip(cap_r, EXP_CYC); // RULE_04
      upd_nxt = 1'b1; // RULE_06
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      add_r <= RSCM_ADD_RST;
      mag_r <= RSCM_MAG_RST;
      upd_r <= 1'b0;
    end else begin
      add_r <= add_nxt;
      mag_r <= mag_nxt;
      upd_r <= upd_nxt;
    end
  end

  assign captured_cycle_count = cap_r;
  assign calibration_add_pulses = add_r;
  assign calibration_mask_pulses = mag_r;
  assign calibration_update = upd_r;

  // checks
  sequence s_trusted_capture;
    evt && state_r == RSCM_MEASURE;
  endsequence

  sequence s_word_written;
    ##2 upd_r;
  endsequence

  a_cap_latch: assert property ( // RULE_02
    @(posedge ref_clk) disable iff (!nrst)
    evt |=> cap_r == $past(cnt_r) + 1'b1)
    else $error("capture does not match counter");

  a_cnt_clear: assert property ( // RULE_03
    @(posedge ref_clk) disable iff (!nrst)
    evt |=> cnt_r == '0 ##1 cnt_r == CNT_W'(1))
    else $error("counter not cleared after capture");

  // sampled nrst keeps the release edge out: the counter still sat in reset
  a_cnt_incr: assert property ( // RULE_02
    @(posedge ref_clk) disable iff (!nrst)
    nrst && !evt |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("counter missed a kernel cycle");

  a_cap_hold: assert property ( // RULE_09
    @(posedge ref_clk) disable iff (!nrst)
    !evt |=> $stable(cap_r))
    else $error("capture changed between events");

  a_cal_sign: assert property ( // RULE_04
    @(posedge ref_clk) disable iff (!nrst)
    s_trusted_capture ##2 1'b1 |-> add_r == (cap_r < EXP_CYC))
    else $error("sign bit wrong for capture");

  a_cal_mag: assert property ( // RULE_04
    @(posedge ref_clk) disable iff (!nrst)
    s_trusted_capture ##2 1'b1 |-> mag_r == rscm_mag_clip(cap_r, EXP_CYC))
    else $error("magnitude wrong for capture");

  a_cal_settle: assert property ( // RULE_06
    @(posedge ref_clk) disable iff (!nrst)
    s_trusted_capture |-> s_word_written)
    else $error("calibration not written after window");

  a_cal_quiet: assert property ( // RULE_06
    @(posedge ref_clk) disable iff (!nrst)
    !upd_r |-> $stable(add_r) && $stable(mag_r))
    else $error("calibration moved without update");

  a_keep_running: assert property ( // RULE_05
    @(posedge ref_clk) disable iff (!nrst)
    state_r == RSCM_MEASURE |=> state_r == RSCM_MEASURE)
    else $error("measurement loop stopped");

  a_first_skip: assert property ( // RULE_05
    @(posedge ref_clk) disable iff (!nrst)
    evt && state_r == RSCM_WAIT_FIRST |=> ##1 !upd_r)
    else $error("partial first window used");
endmodule : rscm_measure
`default_nettype wire

// ### rscm_pkg.sv
`default_nettype none
package rscm_pkg;
  // kernel clock and measurement window
  localparam int unsigned RSCM_CLK_HZ = 10_000_000;
  localparam int unsigned RSCM_WINDOW_S = 32;
  localparam int unsigned RSCM_REF_DIV = 32;
  localparam int unsigned RSCM_SETTLE_S = 64;
  localparam int unsigned RSCM_CNT_W = 32;
  localparam int unsigned RSCM_MAG_W = 9;
  // kernel cycles expected in one window
  localparam logic [63:0] RSCM_EXP_CYC =
    64'(RSCM_CLK_HZ) * 64'(RSCM_WINDOW_S);
  localparam logic [RSCM_MAG_W-1:0] RSCM_MAG_MAX = 9'h1ff;
  localparam logic [RSCM_MAG_W-1:0] RSCM_MAG_RST = 9'h000;
  localparam logic RSCM_ADD_RST = 1'b0;

  typedef enum logic [0:0] {
    RSCM_WAIT_FIRST = 1'b0,
    RSCM_MEASURE = 1'b1
  } rscm_state_type;
endpackage : rscm_pkg
`default_nettype wire

// ### rscm_div_if.sv
`timescale 1ns/10ps
`default_nettype none
// reference edges in, window events out
interface rscm_div_if;
  logic ref_edge;
  logic window_evt;
  modport div (input ref_edge, output window_evt);
  modport ctl (output ref_edge, input window_evt);
endinterface : rscm_div_if
`default_nettype wire

// ### rscm_ref_divider.sv
`timescale 1ns/10ps
`default_nettype none
module rscm_ref_divider
  import rscm_pkg::*;
#(
  parameter int unsigned REF_DIV = RSCM_REF_DIV
) (
  input wire logic ref_clk,
  input wire logic nrst,
  rscm_div_if.div bus
);
  localparam int unsigned DW = $clog2(REF_DIV);
  localparam logic [DW-1:0] LAST = DW'(REF_DIV - 1);

  logic [DW-1:0] edge_cnt_r;
  logic [DW-1:0] edge_cnt_nxt;
  logic evt;

  // one event on every 32nd reference rising edge
  always_comb begin
    edge_cnt_nxt = edge_cnt_r;
    evt = 1'b0;
    if (bus.ref_edge) begin
      if (edge_cnt_r == LAST) begin // RULE_01
        edge_cnt_nxt = '0;
        evt = 1'b1;
      end else begin
        edge_cnt_nxt = edge_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      edge_cnt_r <= '0;
    end else begin
      edge_cnt_r <= edge_cnt_nxt;
    end
  end

  // event is a combinational one-cycle pulse on the edge cycle
  assign bus.window_evt = evt;

  // independent edge tally since the previous event, for checking only
  logic [7:0] chk_edges_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      chk_edges_r <= 8'h00;
    end else if (bus.window_evt) begin
      chk_edges_r <= 8'h00;
    end else if (bus.ref_edge) begin
      chk_edges_r <= chk_edges_r + 8'h01;
    end
  end

  a_div_period: assert property ( // RULE_01
    @(posedge ref_clk) disable iff (!nrst)
    bus.window_evt |-> (bus.ref_edge && chk_edges_r == 8'(REF_DIV - 1)))
    else $error("window event not on 32nd reference edge");

  a_div_no_idle: assert property ( // RULE_01
    @(posedge ref_clk) disable iff (!nrst)
    !bus.ref_edge |-> !bus.window_evt)
    else $error("window event without reference edge");
endmodule : rscm_ref_divider
`default_nettype wire

// ### rscm_ref_gen.sv
`timescale 1ns/10ps
`default_nettype none
module rscm_ref_gen (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [15:0] half_period,
  output logic ref_1hz
);
  logic [15:0] left;

  // the pin has a settled level from time zero on
  initial ref_1hz = 1'b0;

  // free-running square wave; a new period takes hold at the next toggle,
  // so a change never clips the phase already under way
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ref_1hz <= 1'b0;
      left <= 16'h0001;
    end else if (left <= 16'h0001) begin
      ref_1hz <= ~ref_1hz;
      left <= half_period;
    end else begin
      left <= left - 16'h0001;
    end
  end
endmodule : rscm_ref_gen
`default_nettype wire

// ### rscm_measure_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rscm_measure_tb;
  import rscm_pkg::*;
  localparam int CW = 24; // above 20 bits, far from wrapping here
  localparam int DIV = 4; // short windows keep the run brief
  localparam int EXPV = 800;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ref_1hz;
  logic [15:0] half = 16'h0064;
  logic window_event;
  logic add;
  logic upd;
  logic [CW-1:0] capt;
  logic [CW-1:0] held;
  logic [RSCM_MAG_W-1:0] mag;
  int failures = 0;
  int tests_run = 0;
  int ovf, edges, phase, updates, exp_capt;
  // model counts like a controller with a 16-bit timer plus overflow tally
  logic [15:0] gap;
  bit first, skip, prev_ref;
  int tbl[6] = '{100, 99, 101, 200, 37, 36};

  rscm_measure #(.CNT_W(CW), .EXP_CYC(CW'(EXPV)), .REF_DIV(DIV))
    u_rscm_measure (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ref_1hz(ref_1hz),
    .window_event(window_event),
    .captured_cycle_count(capt),
    .calibration_add_pulses(add),
    .calibration_mask_pulses(mag),
    .calibration_update(upd)
  );

  rscm_ref_gen u_rscm_ref_gen (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .half_period(half),
    .ref_1hz(ref_1hz)
  );

  // 10 MHz kernel clock
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      failures++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask : chk

  // sign and clipped magnitude expected for one captured window
  function automatic logic [31:0] cal(input int c);
    int d;
    d = (c < EXPV) ? EXPV - c : c - EXPV;
    if (d > 511) d = 511;
    return {22'h00_0000, c < EXPV, 9'(d)};
  endfunction : cal

  // bounded wait for n more calibration updates
  task automatic wait_upd(input int n);
    int k;
    k = updates + n;
    for (int i = 0; i < 8000 && updates < k; i++) @(posedge ref_clk);
    if (updates < k) begin
      failures++;
      stop_test();
    end
  endtask : wait_upd

  // reference model: event spacing, edge count, capture, calibration word;
  // the window closed by the first event after reset is partial, so skipped
  always @(posedge ref_clk) begin
    if (!nrst) begin
      gap = 16'h0000;
      ovf = 0;
      edges = 0;
      phase = 0;
      first = 1;
      prev_ref = 0;
      held = '0;
    end else begin
      gap++;
      if (gap == 16'h0000) ovf++;
      if (ref_1hz && !prev_ref) edges++;
      prev_ref = ref_1hz;
      chk(upd, phase == 2 && !skip);
      if (phase == 2 && !skip) begin
        chk({add, mag}, cal(exp_capt));
        updates++;
      end
      if (phase == 1) begin
        if (!skip) chk(capt, exp_capt);
        held = capt;
      end else chk(capt, held);
      if (phase != 0) phase = (phase + 1) % 3;
      if (window_event) begin
        if (!first) chk(edges, DIV);
        skip = first;
        first = 0;
        exp_capt = ovf * 65536 + int'(gap);
        gap = 16'h0000;
        ovf = 0;
        edges = 0;
        phase = 1;
      end
    end
  end

  // change the period just after an update so the old phase ends in the
  // next window; the one after that must show the settled word
  initial begin
    int h;
    void'($urandom(60273));
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      h = (i < 6) ? tbl[i] : 40 + $urandom % 160;
      wait_upd(1);
      half <= 16'(h);
      wait_upd(2);
      chk({add, mag}, cal(2 * DIV * h));
    end
    // second reset in mid-window
    repeat (37) @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    wait_upd(2);
    chk({add, mag}, cal(2 * DIV * h));
    stop_test();
  end
endmodule : rscm_measure_tb
`default_nettype wire
